// File: tcc_unit.sv
// Functional notes
// - Capture event copies full 16-bit timer value
// - Mode picks falling, rising, 4th, 16th edge
// - Capture sets sticky flag until software clears
// - Newer capture overwrites unread older value
// - Port writes on output pin can capture
// - Capture mode change may raise false flag
// - Prescaler cleared when off or not capturing
// - Any reset clears the prescaler counter
// - Capture-to-capture mode change keeps prescaler count
// - Compare value with timer on every update
// - Match drives pin per mode, sets flag
// - Writing code 1000 presets output latch high
// - Writing code 1001 presets output latch low
// - Clearing control forces output latch low
// - Software interrupt mode only raises flag
// - Special event match clears the first timer
// - Special event starts conversion if converter enabled
// - Special event never sets timer overflow flag
`timescale 1ns/1ps
module tcc_unit
  import tcc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic UNIT_CONTROL_WR,
  input wire logic [7:0] UNIT_CONTROL_WDATA,
  input wire logic CAPCMP_VALUE_LOW_WR,
  input wire logic CAPCMP_VALUE_HIGH_WR,
  input wire logic [7:0] CAPCMP_WDATA,
  input wire logic [15:0] FIRST_TIMER_COUNT,
  input wire logic FIRST_TIMER_TICK,
  input wire logic UNIT_IRQ_FLAG_CLR,
  input wire logic UNIT_IRQ_ENABLE,
  input wire logic ADC_ENABLE,
  input wire logic PORT_B_DIRECTION_BIT,
  input wire logic PORT_DATA_BIT,
  input wire logic UNIT_PIN_IN,
  output logic UNIT_PIN_OUT,
  output logic UNIT_PIN_OE,
  output logic [7:0] UNIT_CONTROL_REG,
  output logic [15:0] CAPCMP_VALUE,
  output logic UNIT_IRQ_FLAG,
  output logic UNIT_IRQ,
  output logic FIRST_TIMER_CLEAR,
  output logic ADC_START
);

  logic [7:0] ctrl_ff;
  logic [15:0] value_ff;
  logic [3:0] psc_ff;
  logic latch_ff;
  logic flag_ff;
  logic irq_ff;
  logic pin_out_ff;
  logic pin_oe_ff;
  logic tclr_ff;
  logic adc_ff;

  logic [7:0] nxt_ctrl;
  logic [15:0] nxt_value;
  logic [3:0] nxt_psc;
  logic nxt_latch;
  logic nxt_flag;
  logic nxt_pin_out;

  // Mode decode
  wire [3:0] mode = ctrl_ff[TCC_MODE_MSB:TCC_MODE_LSB];
  wire [3:0] wr_mode = UNIT_CONTROL_WDATA[TCC_MODE_MSB:TCC_MODE_LSB];
  wire cap_mode = (mode == TCC_MODE_CAP_FALL) | (mode == TCC_MODE_CAP_RISE) |
                  (mode == TCC_MODE_CAP_R4) | (mode == TCC_MODE_CAP_R16);
  wire cmp_mode = (mode == TCC_MODE_TOGGLE) | (mode == TCC_MODE_CMP_LO) |
                  (mode == TCC_MODE_CMP_HI) | (mode == TCC_MODE_CMP_SWI) |
                  (mode == TCC_MODE_CMP_SPECIAL);
  wire wr_cap_mode = (wr_mode == TCC_MODE_CAP_FALL) | (wr_mode == TCC_MODE_CAP_RISE) |
                     (wr_mode == TCC_MODE_CAP_R4) | (wr_mode == TCC_MODE_CAP_R16);
  wire ctrl_wr_zero = UNIT_CONTROL_WR & (UNIT_CONTROL_WDATA == TCC_CTRL_RST);

  // Level seen at the pin: own drive when output, outside level otherwise
  wire pin_view = pin_oe_ff ? pin_out_ff : UNIT_PIN_IN;

  wire pin_rise;
  wire pin_fall;

  tcc_sync_edge u_sync (
    .clk(CLOCK),
    .rst(SYS_RST),
    .din(pin_view),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Capture event selection
  wire evt_fall = (mode == TCC_MODE_CAP_FALL) & pin_fall;
  wire evt_rise = (mode == TCC_MODE_CAP_RISE) & pin_rise;
  wire evt_r4 = (mode == TCC_MODE_CAP_R4) & pin_rise &
                (psc_ff[1:0] == TCC_PSC4_LAST);
  wire evt_r16 = (mode == TCC_MODE_CAP_R16) & pin_rise &
                 (psc_ff == TCC_PSC16_LAST);
  wire cap_evt = evt_fall | evt_rise | evt_r4 | evt_r16;

  // Compare on each timer update
  wire cmp_match = cmp_mode & FIRST_TIMER_TICK & (FIRST_TIMER_COUNT == value_ff);
  wire special_hit = cmp_match & (mode == TCC_MODE_CMP_SPECIAL);

  // Prescaler: runs only in capture mode, kept across capture-mode changes
  assign nxt_psc = !cap_mode ? TCC_PSC_RST :
                   pin_rise ? psc_ff + 4'h1 : psc_ff;

  // Capture register: capture wins over a software byte write
  wire [15:0] sw_value = {CAPCMP_VALUE_HIGH_WR ? CAPCMP_WDATA : value_ff[15:8],
                          CAPCMP_VALUE_LOW_WR ? CAPCMP_WDATA : value_ff[7:0]};
  assign nxt_value = cap_evt ? FIRST_TIMER_COUNT : sw_value;

  // Flag: hardware set wins over software clear; mode changes can set it too
  assign nxt_flag = cap_evt | cmp_match | (flag_ff & ~UNIT_IRQ_FLAG_CLR);

  // Compare output latch
  wire latch_on_match = (mode == TCC_MODE_TOGGLE) ? ~latch_ff :
                        (mode == TCC_MODE_CMP_LO) ? 1'b0 :
                        (mode == TCC_MODE_CMP_HI) ? 1'b1 : latch_ff;
  wire latch_on_write = ctrl_wr_zero ? TCC_LATCH_RST :
                        (wr_mode == TCC_MODE_CMP_LO) ? 1'b1 :
                        (wr_mode == TCC_MODE_CMP_HI) ? 1'b0 : latch_ff;
  assign nxt_latch = UNIT_CONTROL_WR ? latch_on_write :
                     cmp_match ? latch_on_match : latch_ff;

  assign nxt_ctrl = UNIT_CONTROL_WR ? UNIT_CONTROL_WDATA : ctrl_ff;
  // Same compare-mode set as the decode above, applied to the next control value
  wire nxt_cmp_mode = ((nxt_ctrl[TCC_MODE_MSB:TCC_MODE_LSB] >= TCC_MODE_CMP_LO) &
                       (nxt_ctrl[TCC_MODE_MSB:TCC_MODE_LSB] <= TCC_MODE_CMP_SPECIAL)) |
                      (nxt_ctrl[TCC_MODE_MSB:TCC_MODE_LSB] == TCC_MODE_TOGGLE);
  assign nxt_pin_out = nxt_cmp_mode ? nxt_latch : PORT_DATA_BIT;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ctrl_ff <= TCC_CTRL_RST;
      value_ff <= TCC_VALUE_RST;
      psc_ff <= TCC_PSC_RST;
      latch_ff <= TCC_LATCH_RST;
      flag_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      value_ff <= nxt_value;
      psc_ff <= nxt_psc;
      latch_ff <= nxt_latch;
      flag_ff <= nxt_flag;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      irq_ff <= 1'b0;
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      tclr_ff <= 1'b0;
      adc_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_flag & UNIT_IRQ_ENABLE;
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= ~PORT_B_DIRECTION_BIT;
      tclr_ff <= special_hit;
      adc_ff <= special_hit & ADC_ENABLE;
    end
  end

  // The timer clear is a separate line; the overflow flag is never touched
  assign FIRST_TIMER_CLEAR = tclr_ff;
  assign ADC_START = adc_ff;
  assign UNIT_PIN_OUT = pin_out_ff;
  assign UNIT_PIN_OE = pin_oe_ff;
  assign UNIT_CONTROL_REG = ctrl_ff;
  assign CAPCMP_VALUE = value_ff;
  assign UNIT_IRQ_FLAG = flag_ff;
  assign UNIT_IRQ = irq_ff;

  // Checks

  property p_capture_load;
    @(posedge CLOCK) disable iff (SYS_RST)
    cap_evt |=> (CAPCMP_VALUE == $past(FIRST_TIMER_COUNT));
  endproperty
  a_capture_load: assert property (p_capture_load)
    else $error("capture did not load timer value");

  property p_div4;
    @(posedge CLOCK) disable iff (SYS_RST)
    (mode == TCC_MODE_CAP_R4) && pin_rise && (psc_ff[1:0] != TCC_PSC4_LAST) |-> !cap_evt;
  endproperty
  a_div4: assert property (p_div4)
    else $error("divide-by-4 capture on wrong edge");

  property p_div16;
    @(posedge CLOCK) disable iff (SYS_RST)
    (mode == TCC_MODE_CAP_R16) && pin_rise && (psc_ff == TCC_PSC16_LAST) |-> cap_evt;
  endproperty
  a_div16: assert property (p_div16)
    else $error("sixteenth rising edge missed");

  property p_flag_set;
    @(posedge CLOCK) disable iff (SYS_RST)
    (cap_evt || cmp_match) |=> UNIT_IRQ_FLAG;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set on event");

  property p_flag_hold;
    @(posedge CLOCK) disable iff (SYS_RST)
    UNIT_IRQ_FLAG && !UNIT_IRQ_FLAG_CLR |=> UNIT_IRQ_FLAG;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without clear");

  // A second capture while the first one may still be unread
  sequence s_two_captures;
    cap_evt ##[2:40] cap_evt;
  endsequence

  property p_overwrite;
    @(posedge CLOCK) disable iff (SYS_RST)
    s_two_captures |=> (CAPCMP_VALUE == $past(FIRST_TIMER_COUNT));
  endproperty
  a_overwrite: assert property (p_overwrite)
    else $error("later capture did not overwrite");

  property p_psc_clear;
    @(posedge CLOCK) disable iff (SYS_RST)
    !cap_mode |=> (psc_ff == TCC_PSC_RST);
  endproperty
  a_psc_clear: assert property (p_psc_clear)
    else $error("prescaler not cleared outside capture");

  property p_psc_reset;
    @(posedge CLOCK) disable iff (SYS_RST)
    $fell(SYS_RST) |-> (psc_ff == TCC_PSC_RST);
  endproperty
  a_psc_reset: assert property (p_psc_reset)
    else $error("prescaler not cleared by reset");

  property p_psc_keep;
    @(posedge CLOCK) disable iff (SYS_RST)
    cap_mode && UNIT_CONTROL_WR && wr_cap_mode && !pin_rise |=> (psc_ff == $past(psc_ff));
  endproperty
  a_psc_keep: assert property (p_psc_keep)
    else $error("prescaler lost on capture mode change");

  property p_drive;
    @(posedge CLOCK) disable iff (SYS_RST)
    cmp_match && !UNIT_CONTROL_WR && (mode == TCC_MODE_CMP_HI) |=> latch_ff && UNIT_PIN_OUT;
  endproperty
  a_drive: assert property (p_drive)
    else $error("match did not drive pin high");

  property p_toggle;
    @(posedge CLOCK) disable iff (SYS_RST)
    cmp_match && !UNIT_CONTROL_WR && (mode == TCC_MODE_TOGGLE) |=> (latch_ff != $past(latch_ff));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle on match failed");

  property p_preset;
    @(posedge CLOCK) disable iff (SYS_RST)
    UNIT_CONTROL_WR && (UNIT_CONTROL_WDATA[3:0] == TCC_MODE_CMP_LO) |=> latch_ff;
  endproperty
  a_preset_hi: assert property (p_preset)
    else $error("latch not preset high");

  property p_preset_lo;
    @(posedge CLOCK) disable iff (SYS_RST)
    UNIT_CONTROL_WR && (UNIT_CONTROL_WDATA[3:0] == TCC_MODE_CMP_HI) |=> !latch_ff;
  endproperty
  a_preset_lo: assert property (p_preset_lo)
    else $error("latch not preset low");

  property p_clear_ctrl;
    @(posedge CLOCK) disable iff (SYS_RST)
    ctrl_wr_zero |=> !latch_ff && (UNIT_PIN_OUT == $past(PORT_DATA_BIT));
  endproperty
  a_clear_ctrl: assert property (p_clear_ctrl)
    else $error("clearing control did not reset latch");

  property p_swi;
    @(posedge CLOCK) disable iff (SYS_RST)
    cmp_match && !UNIT_CONTROL_WR && (mode == TCC_MODE_CMP_SWI)
      |=> (latch_ff == $past(latch_ff)) && !FIRST_TIMER_CLEAR && UNIT_IRQ_FLAG;
  endproperty
  a_swi: assert property (p_swi)
    else $error("software interrupt mode touched pin");

  sequence s_clear_pulse;
    FIRST_TIMER_CLEAR ##1 !FIRST_TIMER_CLEAR;
  endsequence

  property p_special;
    @(posedge CLOCK) disable iff (SYS_RST)
    special_hit ##1 !special_hit |-> s_clear_pulse;
  endproperty
  a_special: assert property (p_special)
    else $error("special event did not clear timer");

  property p_adc;
    @(posedge CLOCK) disable iff (SYS_RST)
    ADC_START |-> FIRST_TIMER_CLEAR && $past(ADC_ENABLE);
  endproperty
  a_adc: assert property (p_adc)
    else $error("conversion start without enabled trigger");

endmodule

// File: tcc_pkg.sv
package tcc_pkg;

  // Mode field encodings
  localparam logic [3:0] TCC_MODE_OFF = 4'h0;
  localparam logic [3:0] TCC_MODE_TOGGLE = 4'h2;
  localparam logic [3:0] TCC_MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] TCC_MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] TCC_MODE_CAP_R4 = 4'h6;
  localparam logic [3:0] TCC_MODE_CAP_R16 = 4'h7;
  localparam logic [3:0] TCC_MODE_CMP_LO = 4'h8;
  localparam logic [3:0] TCC_MODE_CMP_HI = 4'h9;
  localparam logic [3:0] TCC_MODE_CMP_SWI = 4'ha;
  localparam logic [3:0] TCC_MODE_CMP_SPECIAL = 4'hb;

  // Control register layout
  localparam int TCC_MODE_LSB = 0;
  localparam int TCC_MODE_MSB = 3;
  localparam logic [7:0] TCC_CTRL_RST = 8'h00;

  // Reset values
  localparam logic [15:0] TCC_VALUE_RST = 16'h0000;
  localparam logic TCC_LATCH_RST = 1'b0;
  localparam logic [3:0] TCC_PSC_RST = 4'h0;

  // Prescaler terminal counts
  localparam logic [1:0] TCC_PSC4_LAST = 2'h3;
  localparam logic [3:0] TCC_PSC16_LAST = 4'hf;

endpackage

// File: tcc_sync_edge.sv
`timescale 1ns/1ps
module tcc_sync_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic rise,
  output logic fall
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // Two-stage synchroniser, then one more stage for the edge compare
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign rise = s2_ff & ~s3_ff;
  assign fall = ~s2_ff & s3_ff;

endmodule

// File: tcc_pin_model.sv
`timescale 1ns/1ps
module tcc_pin_model (
  input wire logic src_level,
  input wire logic drv_level,
  input wire logic drv_en,
  output logic pin_level
);
  // While the unit drives the pin, the wire follows its own drive, so port writes can capture
  assign pin_level = drv_en ? drv_level : src_level;
endmodule

// File: tb_tcc_unit.sv
`timescale 1ns/1ps
module tb_tcc_unit import tcc_pkg::*;;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic ctrl_wr = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00;
  logic lo_wr = 1'b0;
  logic hi_wr = 1'b0;
  logic [7:0] cc_wdata = 8'h00;
  logic [15:0] cnt = 16'h0000;
  logic tick_i = 1'b0;
  logic flag_clr = 1'b0;
  logic irq_en = 1'b1;
  logic adc_en = 1'b0;
  logic dir_bit = 1'b1;
  logic port_bit = 1'b0;
  logic src_lvl = 1'b0;
  logic pin_in, pin_out, pin_oe, irq_flag, irq, tmr_clr, adc_start;
  logic [7:0] ctrl_reg;
  logic [15:0] cc_value;
  int checks = 0;
  int num_errors = 0;
  int cycles = 0;

  always #2.5 clock = ~clock;

  tcc_pin_model u_pin (.src_level(src_lvl), .drv_level(pin_out), .drv_en(pin_oe),
    .pin_level(pin_in));

  tcc_unit DUT (.CLOCK(clock), .SYS_RST(sys_rst), .UNIT_CONTROL_WR(ctrl_wr),
    .UNIT_CONTROL_WDATA(ctrl_wdata), .CAPCMP_VALUE_LOW_WR(lo_wr), .CAPCMP_VALUE_HIGH_WR(hi_wr),
    .CAPCMP_WDATA(cc_wdata), .FIRST_TIMER_COUNT(cnt), .FIRST_TIMER_TICK(tick_i),
    .UNIT_IRQ_FLAG_CLR(flag_clr), .UNIT_IRQ_ENABLE(irq_en), .ADC_ENABLE(adc_en),
    .PORT_B_DIRECTION_BIT(dir_bit), .PORT_DATA_BIT(port_bit), .UNIT_PIN_IN(pin_in),
    .UNIT_PIN_OUT(pin_out), .UNIT_PIN_OE(pin_oe), .UNIT_CONTROL_REG(ctrl_reg),
    .CAPCMP_VALUE(cc_value), .UNIT_IRQ_FLAG(irq_flag), .UNIT_IRQ(irq),
    .FIRST_TIMER_CLEAR(tmr_clr), .ADC_START(adc_start));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wr_ctrl(input logic [7:0] v);
    ctrl_wr = 1'b1;
    ctrl_wdata = v;
    wait_n(1);
    ctrl_wr = 1'b0;
  endtask

  task automatic wr_val(input logic [15:0] v);
    lo_wr = 1'b1;
    cc_wdata = v[7:0];
    wait_n(1);
    lo_wr = 1'b0;
    hi_wr = 1'b1;
    cc_wdata = v[15:8];
    wait_n(1);
    hi_wr = 1'b0;
  endtask

  task automatic clr_flag();
    flag_clr = 1'b1;
    wait_n(1);
    flag_clr = 1'b0;
  endtask

  // Pin rises n times, then lets the synchroniser and edge stage settle
  task automatic rises(input int n);
    for (int i = 0; i < n; i++) begin
      src_lvl = 1'b1;
      wait_n(2);
      src_lvl = 1'b0;
      wait_n(2);
    end
    wait_n(4);
  endtask

  task automatic tick(input logic [15:0] c);
    tick_i = 1'b1;
    cnt = c;
    wait_n(1);
    tick_i = 1'b0;
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    chk(ctrl_reg, 16'h0000);
    chk(cc_value, 16'h0000);
    chk(irq_flag, 1'b0);
    done("reset");
    // Single-edge captures
    wr_ctrl({4'h0, TCC_MODE_CAP_RISE});
    clr_flag();
    cnt = 16'ha5c3;
    rises(1);
    chk(cc_value, 16'ha5c3);
    chk(irq_flag, 1'b1);
    chk(irq, 1'b1);
    wait_n(3);
    chk(irq_flag, 1'b1);
    cnt = 16'h1234;
    rises(1);
    chk(cc_value, 16'h1234);
    clr_flag();
    chk(irq_flag, 1'b0);
    irq_en = 1'b0;
    wr_ctrl({4'h0, TCC_MODE_CAP_FALL});
    clr_flag();
    cnt = 16'h5aa5;
    src_lvl = 1'b1;
    wait_n(6);
    chk(irq_flag, 1'b0);
    src_lvl = 1'b0;
    wait_n(6);
    chk(cc_value, 16'h5aa5);
    chk(irq, 1'b0);
    irq_en = 1'b1;
    done("edges");
    // Prescaled captures; turn the unit off first so the count starts from zero
    wr_ctrl(8'h00);
    wait_n(1);
    wr_ctrl({4'h0, TCC_MODE_CAP_R4});
    clr_flag();
    cnt = 16'h0444;
    rises(3);
    chk(irq_flag, 1'b0);
    rises(1);
    chk(irq_flag, 1'b1);
    chk(cc_value, 16'h0444);
    rises(2);
    wr_ctrl(8'h00);
    wait_n(1);
    wr_ctrl({4'h0, TCC_MODE_CAP_R16});
    clr_flag();
    cnt = 16'h1616;
    rises(15);
    chk(irq_flag, 1'b0);
    rises(1);
    chk(cc_value, 16'h1616);
    wr_ctrl(8'h00);
    wait_n(1);
    wr_ctrl({4'h0, TCC_MODE_CAP_R4});
    rises(2);
    wr_ctrl({4'h0, TCC_MODE_CAP_R16});
    clr_flag();
    rises(13);
    chk(irq_flag, 1'b0);
    rises(1);
    chk(irq_flag, 1'b1);
    done("prescaler");
    // Port write on an output pin
    wr_ctrl({4'h0, TCC_MODE_CAP_RISE});
    dir_bit = 1'b0;
    wait_n(6);
    clr_flag();
    cnt = 16'h0b0b;
    port_bit = 1'b1;
    wait_n(6);
    chk(irq_flag, 1'b1);
    chk(cc_value, 16'h0b0b);
    chk(pin_oe, 1'b1);
    done("port write");
    // Compare actions, pin stays output
    wr_val(16'h0010);
    wr_ctrl({4'h0, TCC_MODE_CMP_LO});
    clr_flag();
    chk(pin_out, 1'b1);
    tick(16'h000f);
    chk(irq_flag, 1'b0);
    cnt = 16'h0010;
    wait_n(2);
    chk(pin_out, 1'b1);
    tick(16'h0010);
    chk(pin_out, 1'b0);
    chk(irq_flag, 1'b1);
    wr_ctrl({4'h0, TCC_MODE_CMP_HI});
    clr_flag();
    chk(pin_out, 1'b0);
    tick(16'h0010);
    chk(pin_out, 1'b1);
    wr_ctrl(8'h00);
    chk(pin_out, 1'b1);
    wait_n(1);
    wr_ctrl({4'h0, TCC_MODE_TOGGLE});
    chk(pin_out, 1'b0);
    tick(16'h0010);
    chk(pin_out, 1'b1);
    wait_n(1);
    tick(16'h0010);
    chk(pin_out, 1'b0);
    wr_ctrl({4'h0, TCC_MODE_CMP_SWI});
    clr_flag();
    tick(16'h0010);
    chk(pin_out, 1'b0);
    chk(irq_flag, 1'b1);
    done("compare");
    // Special event trigger
    wr_ctrl({4'h0, TCC_MODE_CMP_SPECIAL});
    chk(ctrl_reg, {12'h000, TCC_MODE_CMP_SPECIAL});
    adc_en = 1'b1;
    tick(16'h0010);
    chk(tmr_clr, 1'b1);
    chk(adc_start, 1'b1);
    wait_n(1);
    chk(tmr_clr, 1'b0);
    adc_en = 1'b0;
    tick(16'h0010);
    chk(tmr_clr, 1'b1);
    chk(adc_start, 1'b0);
    done("special event");
    report_and_stop();
  end
endmodule
